//--- src/adc_scan_regs.vh
// Constants for the channel selector, scan sequencer and result word.
// Assumes inclusion by the converter control files only.
`ifndef ADC_SCAN_REGS_VH
`define ADC_SCAN_REGS_VH

// Result word layout, bit 23 leaves first
`define RW_WIDTH 24
`define RW_VALUE_MSB 23
`define RW_VALUE_LSB 6
`define RW_RSVD_BIT 5
`define RW_AUX_HI_BIT 4
`define RW_AUX_LO_BIT 3
`define RW_TAG_MSB 2
`define RW_RSVD_VALUE 1'b0
`define RW_RESET 24'h000000
`define WR_DISCARD_BITS 5'h08

// Conversion value, offset binary
`define VALUE_MIN 18'h00000
`define VALUE_MAX 18'h3ffff
`define VALUE_MID 20'sh20000

// Operating modes on {op_mode_hi, op_mode_lo}
`define MODE_NORMAL 2'h0
`define MODE_OFFSET_CAL 2'h1
`define MODE_GAIN_CAL 2'h2

// Internal input pair codes
`define PAIR_SE1 4'h0
`define PAIR_SE5 4'h4
`define PAIR_DIFF1 4'h5
`define PAIR_OFFSET_CAL 4'h8
`define PAIR_GAIN_CAL 4'h9

// Source tags
`define TAG_PAIR_MODE_SELECT_BASE 3'h4
`define TAG_SE5 3'h6
`define TAG_CAL 3'h7

// Transfer-function settings 1..3
`define TF_1 2'h1
`define TF_2 2'h2
`define TF_3 2'h3

// Scan list lengths
`define SCAN_LEN_SE 4'h5
`define SCAN_LEN_PAIR_MODE_SELECT 4'h3
`define SCAN_LEN_CAL_EXTRA 4'h2

// Least settling count before any rate scaling
`define SETTLE_BASE_CYC 1024
`define SETTLE_W 24

`endif

//--- src/sync2.v
// Two-stage level synchroniser for pins from outside the clock domain.
// Assumes the clock enable freezes it along with the rest of the block.
`timescale 1ns/100ps
module sync2 (
  input wire i_clock,
  input wire i_rst,
  input wire i_ce,
  input wire i_async,
  output reg o_sync
);
  reg stage1_r;

  // Only the second stage reads the first one
  always @(posedge i_clock) begin
    // Resets to the idle-high serial clock level to avoid a false edge
    if (i_rst) begin
      stage1_r <= 1'b1;
      o_sync <= 1'b1;
    end else if (i_ce) begin
      stage1_r <= i_async;
      o_sync <= stage1_r;
    end
  end
endmodule

//--- src/settle_timer.v
// Down counter that marks the end of the filter settling interval.
// Assumes a load pulse restarts it and done stays high until the next load.
`timescale 1ns/100ps
`include "adc_scan_regs.vh"
module settle_timer (
  input wire i_clock,
  input wire i_rst,
  input wire i_ce,
  input wire i_load,
  input wire [`SETTLE_W-1:0] i_count,
  output reg o_done
);
  reg [`SETTLE_W-1:0] left_r;

  always @(posedge i_clock) begin
    if (i_rst) begin
      left_r <= {`SETTLE_W{1'b0}};
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        left_r <= i_count;
        o_done <= 1'b0;
      end else if (left_r > {{(`SETTLE_W-1){1'b0}}, 1'b1}) begin
        left_r <= left_r - {{(`SETTLE_W-1){1'b0}}, 1'b1};
      end else begin
        o_done <= 1'b1;
      end
    end
  end
endmodule

//--- src/adc_scan_top.v
// Channel selection, scan sequencing and result word of the converter.
// Assumes setup bits and access pulses come from logic on i_clock; the
// serial clock and auxiliary pins are asynchronous and synchronised here.
// Functional notes
// R01: Result word is 24 bits, read only.
// R02: Writes to result word change nothing.
// R03: After write attempt, eight clocks then idle.
// R04: Shift order: value, reserved, aux, tag.
// R05: Value is 18-bit offset binary, bit17 MSB.
// R06: Out-of-range input saturates at min or max.
// R07: Reserved bit always reads zero.
// R08: Aux bits latched at first falling clock.
// R09: Tag codes source pair; calibration gives 111.
// R10: Three pair_mode_select, five single, two calibration pairs.
// R11: Offset-cal mode converts offset pair, mapped settings.
// R12: Gain-cal mode converts gain pair, mapped settings.
// R13: Host sets scan bit to scan.
// R14: Scan list set by pair mode, op mode.
// R15: One result per channel before advancing.
// R16: Full settling wait per scanned channel.
// R17: Settling follows clock, filter, modulator bits.
// R18: Open-sensor test currents follow setup bit.
// R19: Normal mode: code picks pair; scan signals only.
// R20: Offset calibration scanned before gain calibration.
// R21: Active control change drops ready, resets filter.
// R22: Scan wraps to first channel.
// R23: Host reads all 24 bits to finish.
`timescale 1ns/100ps
`include "adc_scan_regs.vh"
module adc_scan_top #(
  parameter SETTLE_BASE = `SETTLE_BASE_CYC
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_ce,
  input wire i_scan_enable,
  input wire i_pair_mode_select,
  input wire i_op_mode_hi,
  input wire i_op_mode_lo,
  input wire i_chan_code_hi,
  input wire i_chan_code_lo,
  input wire i_clock_rate_select,
  input wire [1:0] i_filter_select,
  input wire [1:0] i_modulator_rate_select,
  input wire i_open_sensor_test_enable,
  input wire signed [19:0] i_filter_value,
  input wire i_read_access,
  input wire i_write_access,
  input wire i_sclk,
  input wire i_aux_level_hi,
  input wire i_aux_level_lo,
  output reg [3:0] o_pair_select,
  output reg [1:0] o_tf_setting,
  output reg o_prohibited_select,
  output reg o_filter_reset,
  output reg o_data_ready_n,
  output reg o_dout,
  output reg o_serial_idle,
  output reg o_open_sensor_test_on
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  // Pair for a scan slot: {pair, tf setting}
  function [5:0] scan_slot;
    input pair_mode_select;
    input [3:0] idx;
    begin
      if (pair_mode_select) begin
        if (idx < `SCAN_LEN_PAIR_MODE_SELECT)
          scan_slot = {`PAIR_DIFF1 + idx, idx[1:0] + `TF_1};
        else
          scan_slot = {`PAIR_OFFSET_CAL + idx - `SCAN_LEN_PAIR_MODE_SELECT, `TF_3};
      end else begin
        if (idx < `SCAN_LEN_SE)
          scan_slot = {`PAIR_SE1 + idx, (idx == 4'h4) ? `TF_3 :
                       (idx[1] ? `TF_2 : `TF_1)};
        else
          scan_slot = {`PAIR_OFFSET_CAL + idx - `SCAN_LEN_SE, `TF_3};
      end
    end
  endfunction

  // Setting for a fixed-channel code
  function [1:0] fixed_tf;
    input pair_mode_select;
    input [1:0] code;
    begin
      if (pair_mode_select)
        fixed_tf = (code == 2'h3) ? `TF_3 : code + `TF_1;
      else
        fixed_tf = code[1] ? `TF_2 : `TF_1;
    end
  endfunction

  // Source tag of a pair
  // Input five shares tag 110 with the third differential pair
  function [2:0] tag_of;
    input [3:0] pair;
    reg [3:0] t;
    begin
      t = `TAG_PAIR_MODE_SELECT_BASE + pair - `PAIR_DIFF1;
      if (pair >= `PAIR_OFFSET_CAL)
        tag_of = `TAG_CAL;
      else if (pair >= `PAIR_DIFF1)
        tag_of = t[2:0];
      else if (pair == `PAIR_SE5)
        tag_of = `TAG_SE5;
      else
        tag_of = pair[2:0];
    end
  endfunction

  // Offset binary with clamping instead of wrap
  function [17:0] sat18;
    input signed [19:0] v;
    reg signed [20:0] s;
    begin
      s = {v[19], v} + {1'b0, `VALUE_MID};
      if (s < 21'sd0)
        sat18 = `VALUE_MIN;
      else if (s > $signed({3'b000, `VALUE_MAX}))
        sat18 = `VALUE_MAX;
      else
        sat18 = s[17:0];
    end
  endfunction

  wire [1:0] mode = {i_op_mode_hi, i_op_mode_lo};
  wire [1:0] code = {i_chan_code_hi, i_chan_code_lo};
  wire cal_mode = (mode == `MODE_OFFSET_CAL) || (mode == `MODE_GAIN_CAL);

  reg [3:0] scan_idx_r;
  reg [3:0] scan_len;
  reg [3:0] pair_nxt;
  reg [1:0] tf_nxt;
  reg prohibited_nxt;
  reg [5:0] slot;

  // Active channel selection
  always @* begin
    scan_len = i_pair_mode_select ? `SCAN_LEN_PAIR_MODE_SELECT : `SCAN_LEN_SE; // [R14]
    if (cal_mode)
      scan_len = scan_len + `SCAN_LEN_CAL_EXTRA; // [R14] [R19]
    slot = scan_slot(i_pair_mode_select, scan_idx_r);
    prohibited_nxt = 1'b0;
    if (i_scan_enable) begin
      pair_nxt = slot[5:2]; // [R14] [R20]
      tf_nxt = slot[1:0];
    end else begin
      tf_nxt = fixed_tf(i_pair_mode_select, code); // [R11] [R12]
      prohibited_nxt = i_pair_mode_select && (code == 2'h3);
      if (mode == `MODE_OFFSET_CAL)
        pair_nxt = `PAIR_OFFSET_CAL; // [R11]
      else if (mode == `MODE_GAIN_CAL)
        pair_nxt = `PAIR_GAIN_CAL; // [R12]
      else if (i_pair_mode_select)
        pair_nxt = `PAIR_DIFF1 + {2'b00, code}; // [R19] [R10]
      else
        pair_nxt = `PAIR_SE1 + {2'b00, code}; // [R19] [R10]
    end
  end

  // Settling scales with decimation and slows at the lower clock rate
  wire [2:0] rate_shift = {1'b0, i_filter_select} + {1'b0, ~i_modulator_rate_select}
                          + {2'b00, ~i_clock_rate_select};
  wire [`SETTLE_W-1:0] settle_cnt = SETTLE_BASE[`SETTLE_W-1:0] << rate_shift; // [R17]

  // Everything that steers the active conversion
  wire [11:0] active_ctl = {i_scan_enable, i_pair_mode_select, mode,
                            i_scan_enable ? 2'b00 : code, i_filter_select,
                            i_modulator_rate_select, i_clock_rate_select, 1'b0};
  reg [11:0] ctl_r;
  reg started_r;
  wire ctl_change = started_r && (ctl_r != active_ctl); // [R21]

  // Timer reloads on every control change and every captured result
  reg load_r;
  wire settled;
  settle_timer u_settle (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_load(load_r),
    .i_count(settle_cnt),
    .o_done(settled)
  );

  wire sclk_s;
  wire aux_hi_s;
  wire aux_lo_s;
  // Pins cross into this clock through two flops each
  sync2 u_sync_sclk (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_async(i_sclk), .o_sync(sclk_s)
  );
  sync2 u_sync_aux_hi (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_async(i_aux_level_hi), .o_sync(aux_hi_s)
  );
  sync2 u_sync_aux_lo (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_async(i_aux_level_lo), .o_sync(aux_lo_s)
  );

  reg sclk_d_r;
  wire sclk_rise = sclk_s && !sclk_d_r;
  wire sclk_fall = !sclk_s && sclk_d_r;

  reg [1:0] ser_state_r;
  reg [4:0] rise_cnt_r;
  reg [4:0] fall_cnt_r;
  reg [`RW_WIDTH-1:0] shift_r;
  reg [17:0] value_r;
  reg [2:0] tag_r;
  reg read_done;

  always @* begin
    read_done = (ser_state_r == ST_READ) && sclk_rise
                && (rise_cnt_r == `RW_WIDTH - 1); // [R23]
  end

  // A result waits while a read is under way so the word stays whole
  wire capture = settled && !load_r && !ctl_change && (ser_state_r != ST_READ);

  // Sequencer: settle, publish one result, then advance
  always @(posedge i_clock) begin
    if (i_rst) begin
      scan_idx_r <= 4'h0;
      ctl_r <= 12'h000;
      started_r <= 1'b0;
      load_r <= 1'b1;
      o_pair_select <= `PAIR_SE1;
      o_tf_setting <= `TF_1;
      o_prohibited_select <= 1'b0;
      o_filter_reset <= 1'b1;
      o_data_ready_n <= 1'b1;
      value_r <= `VALUE_MIN;
      tag_r <= 3'h0;
      o_open_sensor_test_on <= 1'b0;
    end else if (i_ce) begin
      o_open_sensor_test_on <= i_open_sensor_test_enable; // [R18]
      ctl_r <= active_ctl;
      started_r <= 1'b1;
      o_pair_select <= pair_nxt;
      o_tf_setting <= tf_nxt;
      o_prohibited_select <= prohibited_nxt;
      load_r <= 1'b0;
      o_filter_reset <= 1'b0;
      if (ctl_change) begin
        o_data_ready_n <= 1'b1; // [R21]
        o_filter_reset <= 1'b1; // [R21]
        load_r <= 1'b1;
        scan_idx_r <= 4'h0;
      end else if (capture) begin
        value_r <= sat18(i_filter_value); // [R05] [R06]
        tag_r <= tag_of(o_pair_select); // [R09]
        o_data_ready_n <= 1'b0; // [R16]
        if (i_scan_enable) begin // [R13]
          load_r <= 1'b1; // [R15] [R16]
          o_filter_reset <= 1'b1;
          if (scan_idx_r + 4'h1 >= scan_len)
            scan_idx_r <= 4'h0; // [R22]
          else
            scan_idx_r <= scan_idx_r + 4'h1; // [R15]
        end else begin
          load_r <= 1'b1;
        end
      end else if (read_done) begin
        o_data_ready_n <= 1'b1;
      end
    end
  end

  // Serial side of the result word
  always @(posedge i_clock) begin
    if (i_rst) begin
      // Idle-high start so reset leaves no false serial clock edge
      sclk_d_r <= 1'b1;
      ser_state_r <= ST_IDLE;
      rise_cnt_r <= 5'h00;
      fall_cnt_r <= 5'h00;
      shift_r <= `RW_RESET;
      o_dout <= 1'b1;
      o_serial_idle <= 1'b1;
    end else if (i_ce) begin
      sclk_d_r <= sclk_s;
      case (ser_state_r)
        ST_IDLE: begin
          rise_cnt_r <= 5'h00;
          fall_cnt_r <= 5'h00;
          o_dout <= 1'b1;
          if (i_read_access) begin
            shift_r <= {value_r, `RW_RSVD_VALUE, 2'b00, tag_r}; // [R04] [R07]
            ser_state_r <= ST_READ;
            o_serial_idle <= 1'b0;
          end else if (i_write_access) begin
            ser_state_r <= ST_WRITE; // [R02]
            o_serial_idle <= 1'b0;
          end
        end
        ST_READ: begin
          if (sclk_fall && fall_cnt_r < `RW_WIDTH) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
            // Aux pin levels enter the word at the first falling edge only
            if (fall_cnt_r == 5'h00) begin
              o_dout <= shift_r[`RW_VALUE_MSB]; // [R04]
              shift_r <= {shift_r[`RW_WIDTH-2:`RW_RSVD_BIT], aux_hi_s, aux_lo_s,
                          shift_r[`RW_TAG_MSB:0], 1'b0}; // [R08]
            end else begin
              o_dout <= shift_r[`RW_VALUE_MSB];
              shift_r <= {shift_r[`RW_WIDTH-2:0], 1'b0};
            end
          end
          if (sclk_rise)
            rise_cnt_r <= rise_cnt_r + 5'h01;
          if (read_done) begin
            ser_state_r <= ST_IDLE; // [R23]
            o_serial_idle <= 1'b1;
            o_dout <= 1'b1;
          end
        end
        ST_WRITE: begin
          // Shifted-in bits are dropped; result word untouched
          if (sclk_rise) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
            if (rise_cnt_r == `WR_DISCARD_BITS - 5'h01) begin
              ser_state_r <= ST_IDLE; // [R03] [R01]
              o_serial_idle <= 1'b1;
            end
          end
        end
        default: begin
          ser_state_r <= ST_IDLE;
          o_serial_idle <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- test/adc_scan_monitor.sv
// Assertions on pair selection, restart on control change and serial idle.
// Assumes binding into adc_scan_top; settings hold still while i_ce is low.
`timescale 1ns/100ps
module adc_scan_monitor #(
  parameter SETTLE_BASE = 4
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_scan_enable,
  input wire i_pair_mode_select,
  input wire i_op_mode_hi,
  input wire i_op_mode_lo,
  input wire i_chan_code_hi,
  input wire i_chan_code_lo,
  input wire i_open_sensor_test_enable,
  input wire i_read_access,
  input wire i_write_access,
  input wire [3:0] o_pair_select,
  input wire [1:0] o_tf_setting,
  input wire o_prohibited_select,
  input wire o_filter_reset,
  input wire o_data_ready_n,
  input wire o_dout,
  input wire o_serial_idle,
  input wire o_open_sensor_test_on
);
  wire [1:0] mode = {i_op_mode_hi, i_op_mode_lo};
  wire [1:0] code = {i_chan_code_hi, i_chan_code_lo};
  wire [5:0] ctl = {i_scan_enable, i_pair_mode_select, mode, code};
  wire [3:0] np = i_pair_mode_select ? 4'h5 + code : {2'h0, code};
  wire [1:0] ntf = i_pair_mode_select ? code + 2'h1 : {1'b0, code[1]} + 2'h1;
  wire sel = !i_scan_enable && !(i_pair_mode_select && code == 2'h3);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Settings must sit still long enough to pass the change detector
  sequence s_held(c);
    (c && $stable(ctl)) [*5];
  endsequence
  sequence s_open(a);
    a && o_serial_idle;
  endsequence
  chk_offset_pair:
    assert property (s_held(sel && mode == 2'h1) |-> o_pair_select == 4'h8)
    else $error("offset calibration pair not selected");
  chk_gain_pair:
    assert property (s_held(sel && mode == 2'h2) |-> o_pair_select == 4'h9)
    else $error("gain calibration pair not selected");
  chk_normal_pair:
    assert property (s_held(sel && mode == 2'h0) |-> o_pair_select == np)
    else $error("wrong input pair in normal mode");
  chk_tf_map:
    assert property (s_held(sel) |-> o_tf_setting == ntf && !o_prohibited_select)
    else $error("wrong transfer setting");
  chk_prohib_flag:
    assert property (s_held(!i_scan_enable && i_pair_mode_select && code == 2'h3)
      |-> o_prohibited_select)
    else $error("prohibited code not flagged");
  chk_ctl_restart:
    assert property ($changed({i_scan_enable, i_pair_mode_select, mode})
      |-> ##[1:3] (o_filter_reset && o_data_ready_n))
    else $error("control change did not restart filter");
  chk_test_follow:
    assert property (!$past(i_rst) |-> o_open_sensor_test_on == $past(i_open_sensor_test_enable))
    else $error("test currents do not follow setup");
  chk_idle_dout:
    assert property (o_serial_idle |-> o_dout)
    else $error("data out not high while idle");
  chk_read_busy:
    assert property (s_open(i_read_access) |=> !o_serial_idle [*8])
    else $error("read access did not leave idle");
  chk_write_busy:
    assert property (s_open(i_write_access) |=> !o_serial_idle [*8])
    else $error("write access did not hold off idle");
endmodule
bind adc_scan_top adc_scan_monitor #(.SETTLE_BASE(SETTLE_BASE)) u_mon (.i_clock, .i_rst,
  .i_scan_enable, .i_pair_mode_select, .i_op_mode_hi, .i_op_mode_lo, .i_chan_code_hi,
  .i_chan_code_lo, .i_open_sensor_test_enable, .i_read_access, .i_write_access,
  .o_pair_select, .o_tf_setting, .o_prohibited_select, .o_filter_reset, .o_data_ready_n,
  .o_dout, .o_serial_idle, .o_open_sensor_test_on);

//--- test/serial_host.sv
// Serial master model: clocks a frame of i_bits bits, sampling data out.
// Assumes a one-cycle i_start while o_busy is low.
`timescale 1ns/100ps
module serial_host (
  input wire i_clock,
  input wire i_start,
  input wire [4:0] i_bits,
  input wire i_dout,
  output reg o_sclk,
  output reg [23:0] o_word,
  output reg o_busy
);
  integer n;
  // Six clocks a half period: 48 ns link clock, idle high between frames
  initial begin
    o_sclk = 1'b1;
    o_busy = 1'b0;
    o_word = 24'h000000;
    forever begin
      @(posedge i_clock);
      if (i_start) begin
        o_busy <= 1'b1;
        for (n = 0; n < i_bits; n = n + 1) begin
          repeat (6) @(posedge i_clock);
          o_sclk <= 1'b0;
          repeat (6) @(posedge i_clock);
          o_word <= {o_word[22:0], i_dout};
          o_sclk <= 1'b1;
        end
        repeat (6) @(posedge i_clock);
        o_busy <= 1'b0;
      end
    end
  end
endmodule

//--- test/adc_scan_top_bench.sv
// Bench for pair selection, scan order, settling and the result word.
// Assumes serial_host drives the serial clock.
`timescale 1ns/100ps
module adc_scan_top_bench;
  localparam [23:0] RCTL = {6'b001000, 6'b000100, 6'b000010, 6'b010000};
  localparam [79:0] RVAL = {20'h80000, 20'h7ffff, 20'hfffff, 20'h00000};
  localparam [11:0] RTAG = {3'h7, 3'h7, 3'h2, 3'h4};
  localparam [19:0] RATE = {5'b11000, 5'b00010, 5'b10111, 5'b10011};
  localparam [17:0] SCTL = {6'b101000, 6'b110100, 6'b100000};
  localparam [95:0] SLST = {32'h09843210, 32'h00598765, 32'h00043210};
  localparam [11:0] SLEN = {4'h8, 4'h6, 4'h6};
  reg i_clock = 1'b0;
  reg i_rst = 1'b1;
  reg [5:0] ctl = 6'h00;
  reg [4:0] rate = 5'h13;
  reg [1:0] aux = 2'h0;
  reg i_open_sensor_test_enable = 1'b0;
  reg signed [19:0] i_filter_value = 20'sh00000;
  reg i_read_access = 1'b0;
  reg i_write_access = 1'b0;
  reg start = 1'b0;
  reg ce = 1'b1;
  reg [4:0] nbits = 5'h18;
  wire [3:0] o_pair_select;
  wire [1:0] o_tf_setting;
  wire o_prohibited_select, o_filter_reset, o_data_ready_n, o_dout, o_serial_idle;
  wire o_open_sensor_test_on, i_sclk, busy;
  wire [23:0] word;
  integer errors = 0;
  integer tests_run = 0;
  integer i, j, k;
  reg [23:0] e;
  always #2 i_clock = ~i_clock;
  adc_scan_top #(.SETTLE_BASE(4)) u_dut (.i_clock, .i_rst, .i_ce(ce),
    .i_scan_enable(ctl[5]), .i_pair_mode_select(ctl[4]), .i_op_mode_hi(ctl[3]),
    .i_op_mode_lo(ctl[2]), .i_chan_code_hi(ctl[1]), .i_chan_code_lo(ctl[0]),
    .i_clock_rate_select(rate[4]), .i_filter_select(rate[3:2]),
    .i_modulator_rate_select(rate[1:0]), .i_open_sensor_test_enable, .i_filter_value,
    .i_read_access, .i_write_access, .i_sclk, .i_aux_level_hi(aux[1]),
    .i_aux_level_lo(aux[0]), .o_pair_select, .o_tf_setting, .o_prohibited_select,
    .o_filter_reset, .o_data_ready_n, .o_dout, .o_serial_idle, .o_open_sensor_test_on);
  serial_host u_host (.i_clock, .i_start(start), .i_bits(nbits), .i_dout(o_dout),
    .o_sclk(i_sclk), .o_word(word), .o_busy(busy));
  task end_sim;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [23:0] seen, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge i_clock);
  endtask
  task wait_rdy;
    begin
      k = 0;
      while (o_data_ready_n !== 1'b0 && k < 3000) begin tick(1); k = k + 1; end
      if (k >= 3000) begin errors = errors + 1; end_sim; end
    end
  endtask
  // Aux pins flip mid-frame: only the level at the first falling edge counts
  task xfer(input is_rd, input [4:0] n);
    begin
      i_read_access <= is_rd;
      i_write_access <= !is_rd;
      start <= 1'b1;
      nbits <= n;
      tick(1);
      i_read_access <= 1'b0;
      i_write_access <= 1'b0;
      start <= 1'b0;
      tick(40);
      aux <= ~aux;
      k = 0;
      while (busy !== 1'b0 && k < 400) begin tick(1); k = k + 1; end
      if (k >= 400) begin errors = errors + 1; end_sim; end
      tick(4);
      check({o_serial_idle, o_dout}, 2'h3);
    end
  endtask
  function [1:0] tf_of(input [3:0] p);
    tf_of = (p < 4'h2 || p == 4'h5) ? 2'h1 : (p < 4'h4 || p == 4'h6) ? 2'h2 : 2'h3;
  endfunction
  function [17:0] ob(input signed [19:0] v);
    reg signed [20:0] s;
    begin
      s = v + 21'sh20000;
      ob = (s < 0) ? 18'h00000 : (s > 21'sh3ffff) ? 18'h3ffff : s[17:0];
    end
  endfunction
  initial begin
    tick(10);
    i_rst <= 1'b0;
    tick(2);
    for (i = 0; i < 24; i = i + 1) begin
      ctl <= {1'b0, i[2], i[4:3], i[1:0]};
      k = i[2] ? 5 + i[1:0] : i[1:0];
      tick(8);
      e[3:0] = (i[4:3] == 2'h1) ? 4'h8 : (i[4:3] == 2'h2) ? 4'h9 : k[3:0];
      if (i[2:0] == 3'h7) check(o_prohibited_select, 1'b1);
      else check({o_prohibited_select, o_pair_select, o_tf_setting}, {e[3:0], tf_of(k[3:0])});
    end
    for (i = 0; i < 4; i = i + 1) begin
      ctl <= RCTL[6*i +: 6];
      i_filter_value <= RVAL[20*i +: 20];
      aux <= i[1:0];
      tick(3);
      wait_rdy;
      xfer(1'b1, 5'h18);
      check(word, {ob(RVAL[20*i +: 20]), 1'b0, i[1:0], RTAG[3*i +: 3]});
    end
    xfer(1'b0, 5'h08);
    xfer(1'b1, 5'h18);
    check(word, {18'h00000, 1'b0, 2'h3, 3'h7});
    ctl <= 6'b010001;
    for (i = 0; i < 4; i = i + 1) begin
      rate <= RATE[5*i +: 5];
      tick(3);
      wait_rdy;
      j = 4 << (rate[3:2] + 3 - rate[1:0] + !rate[4]);
      check(k + 3 >= j && k + 3 <= j + 8, 1'b1);
    end
    rate <= 5'h13;
    for (i = 0; i < 3; i = i + 1) begin
      ctl <= SCTL[6*i +: 6];
      tick(4);
      check(o_pair_select, SLST[32*i +: 4]);
      for (j = 1; j < SLEN[4*i +: 4]; j = j + 1) begin
        e[3:0] = o_pair_select;
        k = 0;
        while (o_pair_select === e[3:0] && k < 300) begin tick(1); k = k + 1; end
        if (k >= 300) begin errors = errors + 1; end_sim; end
        check(k >= 4 || j == 1, 1'b1);
        check(o_pair_select, SLST[32*i + 4*j +: 4]);
        check(o_tf_setting, tf_of(SLST[32*i + 4*j +: 4]));
      end
    end
    for (i = 1; i >= 0; i = i - 1) begin
      i_open_sensor_test_enable <= i[0];
      tick(3);
      check(o_open_sensor_test_on, i[0]);
    end
    // Clock enable low must freeze the scan in its current slot
    ce <= 1'b0;
    tick(2);
    e[3:0] = o_pair_select;
    tick(40);
    check(o_pair_select, e[3:0]);
    ce <= 1'b1;
    tick(2);
    end_sim;
  end
endmodule
